//--- hw/dtc_params.svh
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// Register addresses in special function register space
`define DTC_ADDR_CTRL       8'h88
`define DTC_ADDR_MODE       8'h89
`define DTC_ADDR_CNT_A_LO   8'h8a
`define DTC_ADDR_CNT_B_LO   8'h8b
`define DTC_ADDR_CNT_A_HI   8'h8c
`define DTC_ADDR_TH1        8'h8d
`define DTC_ADDR_IRQ_MASK   8'ha8

// Timer mode register fields
`define DTC_A_MODE_LO_BIT   0
`define DTC_A_MODE_HI_BIT   1
`define DTC_A_SRC_BIT       2
`define DTC_A_GATE_BIT      3
`define DTC_B_MODE_LO_BIT   4
`define DTC_B_MODE_HI_BIT   5
`define DTC_T1_CT_BIT       6
`define DTC_T1_GATE_BIT     7

// Timer control register fields
`define DTC_CTRL_RUN_A_BIT  4
`define DTC_CTRL_FLAG_A_BIT 5
`define DTC_CTRL_RUN_B_BIT  6
`define DTC_CTRL_FLAG_B_BIT 7
`define DTC_CTRL_RW_MASK    8'hf0

// Interrupt enable register fields
`define DTC_MASK_TA_BIT     1
`define DTC_MASK_TB_BIT     3
`define DTC_MASK_GLOBAL_BIT 7
`define DTC_MASK_RW         8'hdf

// Values
`define DTC_RESET_BYTE      8'h00
`define DTC_BYTE_MAX        8'hff
`define DTC_PRESC_MAX       5'h1f
`define DTC_PRESC_MSB       4
`define DTC_ONE_BYTE        8'h01
`define DTC_ONE_PRESC       5'h01
`define DTC_ONE_WORD        16'h0001

`endif

//--- hw/dtc_pkg.sv
`include "dtc_params.svh"

package dtc_pkg;

  typedef enum logic [1:0] {
    DTC_MODE_13,
    DTC_MODE_16,
    DTC_MODE_8R,
    DTC_MODE_SPLIT
  } dtc_mode_e;

  function automatic logic [7:0] byte_inc(input logic [7:0] v);
    byte_inc = v + `DTC_ONE_BYTE;
  endfunction : byte_inc

  function automatic logic [15:0] word_inc(input logic [15:0] v);
    word_inc = v + `DTC_ONE_WORD;
  endfunction : word_inc

endpackage : dtc_pkg

//--- hw/dtc_count_unit.sv
`include "dtc_params.svh"

module dtc_count_unit (
  input  wire logic              inc_low,
  input  dtc_pkg::dtc_mode_e     mode,
  input  wire logic [7:0]        low_cur,
  input  wire logic [7:0]        high_cur,
  output logic      [7:0]        low_new,
  output logic      [7:0]        high_new,
  output logic                   ovf
);

  logic [15:0] word_new;
  logic [4:0]  presc_new;

  always_comb begin
    word_new  = dtc_pkg::word_inc({high_cur, low_cur});
    presc_new = low_cur[`DTC_PRESC_MSB:0] + `DTC_ONE_PRESC;
    low_new   = low_cur;
    high_new  = high_cur;
    ovf       = 1'b0;
    if (inc_low) begin
      case (mode)
        dtc_pkg::DTC_MODE_13: begin
          // Low five bits prescale the high byte
          low_new = {low_cur[7:`DTC_PRESC_MSB+1], presc_new};
          if (low_cur[`DTC_PRESC_MSB:0] == `DTC_PRESC_MAX) begin
            high_new = dtc_pkg::byte_inc(high_cur);
            ovf      = (high_cur == `DTC_BYTE_MAX);
          end
        end
        dtc_pkg::DTC_MODE_16: begin
          low_new  = word_new[7:0];
          high_new = word_new[15:8];
          ovf      = ({high_cur, low_cur} == {`DTC_BYTE_MAX, `DTC_BYTE_MAX});
        end
        dtc_pkg::DTC_MODE_8R: begin
          if (low_cur == `DTC_BYTE_MAX) begin
            low_new = high_cur;
            ovf     = 1'b1;
          end else begin
            low_new = dtc_pkg::byte_inc(low_cur);
          end
        end
        dtc_pkg::DTC_MODE_SPLIT: begin
          low_new = dtc_pkg::byte_inc(low_cur);
          ovf     = (low_cur == `DTC_BYTE_MAX);
        end
        default: begin
          low_new = low_cur;
        end
      endcase
    end
  end

endmodule : dtc_count_unit

//--- hw/dtc_top.sv
// Function
// - Gate set: timer 0 needs pin high
// - Gate clear: timer 0 runs on run bit
// - Source clear: count internal clock
// - Source set: count pin falling edges
// - Mode 0: five-bit prescaler, 8-bit count
// - Mode 1: full 16-bit count
// - Mode 2: low byte reloads from high
// - Split: timer 0 low uses own controls
// - Split: timer 0 high uses timer 1 run
// - Timer 1 mode 3 holds its value
// - Timer 0 mode bits at 1, 0
// - Timer 1 mode low bit at 4
// - Timer 0 low byte at 8Ah
// - Timer 1 low byte at 8Bh
// - Timer 0 high byte at 8Ch
// - Timer 0 interrupt enable bit 1
// - Timer 1 interrupt enable bit 3
// - Bit 7 masks all interrupts globally
`include "dtc_params.svh"

module dtc_top (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  input  wire logic        ext_irq_pin_a,
  input  wire logic        count_input_pin_a,
  input  wire logic        ext_irq_pin_b,
  input  wire logic        count_input_pin_b,
  output logic             timer_a_ovf_flag,
  output logic             timer_b_ovf_flag,
  output logic             timer_a_irq_req,
  output logic             timer_b_irq_req,
  output logic             irq_global_on
);

  function automatic logic sfr_hit(input logic [7:0] addr,
                                   input logic [7:0] target);
    sfr_hit = (addr == target);
  endfunction : sfr_hit

  logic [7:0] cnt_a_lo_reg;
  logic [7:0] cnt_a_hi_reg;
  logic [7:0] cnt_b_lo_reg;
  logic [7:0] th1_reg;
  logic [7:0] mode_reg;
  logic [7:0] irq_enable_mask_reg;
  logic       run_bit_timer_a;
  logic       run_bit_timer_b;
  logic       flag_a_reg;
  logic       flag_b_reg;
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [1:0] count_prev;

  logic       wr_a_lo;
  logic       wr_a_hi;
  logic       wr_b_lo;
  logic       wr_th1;
  logic       wr_mode;
  logic       wr_ctrl;
  logic       wr_ie;
  logic       irq_a_s;
  logic       irq_b_s;
  logic       fall_a;
  logic       fall_b;
  logic       gate_a;
  logic       gate_b;
  logic       src_a;
  logic       src_b;
  logic       en_a;
  logic       en_b;
  logic       inc_low_a;
  logic       inc_low_b;
  logic       inc_high_split;
  logic       split_a;
  logic       ovf_a;
  logic       ovf_b;
  logic       ovf_split_high;
  logic       set_flag_a;
  logic       set_flag_b;
  logic [7:0] a_lo_new;
  logic [7:0] a_hi_new;
  logic [7:0] b_lo_new;
  logic [7:0] th1_new;
  logic [7:0] cnt_a_hi_next;
  logic [7:0] ctrl_view;
  logic       irq_on_timer_a;
  logic       irq_on_timer_b;

  dtc_pkg::dtc_mode_e mode_a;
  dtc_pkg::dtc_mode_e mode_b;

  // Register decode
  assign wr_a_lo = sfr_wr && sfr_hit(sfr_addr, `DTC_ADDR_CNT_A_LO);
  assign wr_b_lo = sfr_wr && sfr_hit(sfr_addr, `DTC_ADDR_CNT_B_LO);
  assign wr_a_hi = sfr_wr && sfr_hit(sfr_addr, `DTC_ADDR_CNT_A_HI);
  assign wr_th1  = sfr_wr && sfr_hit(sfr_addr, `DTC_ADDR_TH1);
  assign wr_mode = sfr_wr && sfr_hit(sfr_addr, `DTC_ADDR_MODE);
  assign wr_ctrl = sfr_wr && sfr_hit(sfr_addr, `DTC_ADDR_CTRL);
  assign wr_ie   = sfr_wr && sfr_hit(sfr_addr, `DTC_ADDR_IRQ_MASK);

  // Mode fields
  assign mode_a = dtc_pkg::dtc_mode_e'(
    mode_reg[`DTC_A_MODE_HI_BIT:`DTC_A_MODE_LO_BIT]);
  assign mode_b = dtc_pkg::dtc_mode_e'(
    mode_reg[`DTC_B_MODE_HI_BIT:`DTC_B_MODE_LO_BIT]);
  assign gate_a  = mode_reg[`DTC_A_GATE_BIT];
  assign gate_b  = mode_reg[`DTC_T1_GATE_BIT];
  assign src_a   = mode_reg[`DTC_A_SRC_BIT];
  assign src_b   = mode_reg[`DTC_T1_CT_BIT];
  assign split_a = (mode_a == dtc_pkg::DTC_MODE_SPLIT);

  // Pin synchronisers, order: irq a, count a, irq b, count b
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      pin_meta <= {count_input_pin_b, ext_irq_pin_b,
                   count_input_pin_a, ext_irq_pin_a};
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_prev <= 2'h0;
    end else begin
      count_prev <= {pin_sync[3], pin_sync[1]};
    end
  end

  assign irq_a_s = pin_sync[0];
  assign irq_b_s = pin_sync[2];
  assign fall_a  = count_prev[0] && !pin_sync[1];
  assign fall_b  = count_prev[1] && !pin_sync[3];

  // Run qualification and count source
  assign en_a = run_bit_timer_a && (!gate_a || irq_a_s);
  assign en_b = run_bit_timer_b && (!gate_b || irq_b_s);
  assign inc_low_a = en_a && (src_a ? fall_a : 1'b1);
  assign inc_low_b = en_b && (src_b ? fall_b : 1'b1) &&
                     (mode_b != dtc_pkg::DTC_MODE_SPLIT);
  assign inc_high_split = split_a && run_bit_timer_b;

  dtc_count_unit u_count_a (
    .inc_low  (inc_low_a),
    .mode     (mode_a),
    .low_cur  (cnt_a_lo_reg),
    .high_cur (cnt_a_hi_reg),
    .low_new  (a_lo_new),
    .high_new (a_hi_new),
    .ovf      (ovf_a)
  );

  dtc_count_unit u_count_b (
    .inc_low  (inc_low_b),
    .mode     (mode_b),
    .low_cur  (cnt_b_lo_reg),
    .high_cur (th1_reg),
    .low_new  (b_lo_new),
    .high_new (th1_new),
    .ovf      (ovf_b)
  );

  // Split mode high byte of timer 0: internal clock only
  assign cnt_a_hi_next = inc_high_split ? dtc_pkg::byte_inc(cnt_a_hi_reg) :
                                          a_hi_new;
  assign ovf_split_high = inc_high_split && (cnt_a_hi_reg == `DTC_BYTE_MAX);

  // Timer 1 loses its flag to the split high byte
  assign set_flag_a = ovf_a;
  assign set_flag_b = split_a ? ovf_split_high : ovf_b;

  // Count bytes: a software write wins over counting
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_a_lo_reg <= `DTC_RESET_BYTE;
    end else if (wr_a_lo) begin
      cnt_a_lo_reg <= sfr_wdata;
    end else begin
      cnt_a_lo_reg <= a_lo_new;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_a_hi_reg <= `DTC_RESET_BYTE;
    end else if (wr_a_hi) begin
      cnt_a_hi_reg <= sfr_wdata;
    end else begin
      cnt_a_hi_reg <= cnt_a_hi_next;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_b_lo_reg <= `DTC_RESET_BYTE;
    end else if (wr_b_lo) begin
      cnt_b_lo_reg <= sfr_wdata;
    end else begin
      cnt_b_lo_reg <= b_lo_new;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      th1_reg <= `DTC_RESET_BYTE;
    end else if (wr_th1) begin
      th1_reg <= sfr_wdata;
    end else begin
      th1_reg <= th1_new;
    end
  end

  // Configuration
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= `DTC_RESET_BYTE;
    end else if (wr_mode) begin
      mode_reg <= sfr_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable_mask_reg <= `DTC_RESET_BYTE;
    end else if (wr_ie) begin
      irq_enable_mask_reg <= sfr_wdata & `DTC_MASK_RW;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_bit_timer_a <= 1'b0;
      run_bit_timer_b <= 1'b0;
    end else if (wr_ctrl) begin
      run_bit_timer_a <= sfr_wdata[`DTC_CTRL_RUN_A_BIT];
      run_bit_timer_b <= sfr_wdata[`DTC_CTRL_RUN_B_BIT];
    end
  end

  // Overflow flags: hardware set beats software write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_a_reg <= 1'b0;
    end else if (set_flag_a) begin
      flag_a_reg <= 1'b1;
    end else if (wr_ctrl) begin
      flag_a_reg <= sfr_wdata[`DTC_CTRL_FLAG_A_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_b_reg <= 1'b0;
    end else if (set_flag_b) begin
      flag_b_reg <= 1'b1;
    end else if (wr_ctrl) begin
      flag_b_reg <= sfr_wdata[`DTC_CTRL_FLAG_B_BIT];
    end
  end

  // Interrupt requests
  assign irq_on_timer_a = irq_enable_mask_reg[`DTC_MASK_TA_BIT];
  assign irq_on_timer_b = irq_enable_mask_reg[`DTC_MASK_TB_BIT];
  assign irq_global_on  = irq_enable_mask_reg[`DTC_MASK_GLOBAL_BIT];
  assign timer_a_irq_req = flag_a_reg && irq_on_timer_a &&
                           irq_global_on;
  assign timer_b_irq_req = flag_b_reg && irq_on_timer_b &&
                           irq_global_on;
  assign timer_a_ovf_flag = flag_a_reg;
  assign timer_b_ovf_flag = flag_b_reg;

  always_comb begin
    ctrl_view = `DTC_RESET_BYTE;
    ctrl_view[`DTC_CTRL_RUN_A_BIT]  = run_bit_timer_a;
    ctrl_view[`DTC_CTRL_FLAG_A_BIT] = flag_a_reg;
    ctrl_view[`DTC_CTRL_RUN_B_BIT]  = run_bit_timer_b;
    ctrl_view[`DTC_CTRL_FLAG_B_BIT] = flag_b_reg;
  end

  // Read data registered one cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= `DTC_RESET_BYTE;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `DTC_ADDR_CNT_A_LO: sfr_rdata <= cnt_a_lo_reg;
        `DTC_ADDR_CNT_B_LO: sfr_rdata <= cnt_b_lo_reg;
        `DTC_ADDR_CNT_A_HI: sfr_rdata <= cnt_a_hi_reg;
        `DTC_ADDR_TH1:  sfr_rdata <= th1_reg;
        `DTC_ADDR_MODE: sfr_rdata <= mode_reg;
        `DTC_ADDR_CTRL: sfr_rdata <= ctrl_view;
        `DTC_ADDR_IRQ_MASK: sfr_rdata <= irq_enable_mask_reg;
        default:        sfr_rdata <= `DTC_RESET_BYTE;
      endcase
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic [15:0] cnt_a16;
  assign cnt_a16 = {cnt_a_hi_reg, cnt_a_lo_reg};

  AST_GATE_BLOCKS:
  assert property ((gate_a && !irq_a_s && !wr_a_lo)
                   |=> cnt_a_lo_reg == $past(cnt_a_lo_reg))
    else $error("gated timer 0 low byte moved");

  AST_UNGATED_RUN:
  assert property ((!gate_a && run_bit_timer_a && !src_a && !wr_a_lo &&
                    !wr_a_hi && mode_a == dtc_pkg::DTC_MODE_16)
                   |=> cnt_a16 == dtc_pkg::word_inc($past(cnt_a16)))
    else $error("ungated 16-bit timer 0 did not advance");

  AST_TIMER_TICK:
  assert property ((run_bit_timer_a && !gate_a && !src_a && !wr_a_lo &&
                    split_a)
                   |=> cnt_a_lo_reg == dtc_pkg::byte_inc($past(cnt_a_lo_reg)))
    else $error("timer 0 missed an internal tick");

  AST_EDGE_ONLY:
  assert property ((src_a && !fall_a && !wr_a_lo)
                   |=> cnt_a_lo_reg == $past(cnt_a_lo_reg))
    else $error("counter advanced without a falling edge");

  AST_PRESCALE:
  assert property ((mode_a == dtc_pkg::DTC_MODE_13 && !wr_a_hi &&
                    cnt_a_lo_reg[`DTC_PRESC_MSB:0] != `DTC_PRESC_MAX)
                   |=> cnt_a_hi_reg == $past(cnt_a_hi_reg))
    else $error("high byte moved before prescaler wrapped");

  AST_RELOAD:
  assert property ((mode_a == dtc_pkg::DTC_MODE_8R && inc_low_a && !wr_a_lo &&
                    cnt_a_lo_reg == `DTC_BYTE_MAX)
                   |=> cnt_a_lo_reg == $past(cnt_a_hi_reg) && flag_a_reg)
    else $error("auto reload did not load high byte");

  AST_RELOAD_SAME_CYCLE:
  assert property ((mode_a == dtc_pkg::DTC_MODE_8R && !wr_a_lo &&
                    $changed(cnt_a_lo_reg) &&
                    $past(cnt_a_lo_reg) == `DTC_BYTE_MAX)
                   |-> $rose(flag_a_reg) || $past(flag_a_reg))
    else $error("reload and overflow flag not in step");

  AST_SPLIT_HIGH:
  assert property ((split_a && run_bit_timer_b && !wr_a_hi)
                   |=> cnt_a_hi_reg == dtc_pkg::byte_inc($past(cnt_a_hi_reg)))
    else $error("split high byte did not follow timer 1 run");

  AST_T1_HOLD:
  assert property ((mode_b == dtc_pkg::DTC_MODE_SPLIT && !wr_b_lo && !wr_th1)
                   |=> $stable(cnt_b_lo_reg) && $stable(th1_reg))
    else $error("timer 1 moved in mode 3");

  AST_GLOBAL_MASK:
  assert property (!irq_global_on |-> !timer_a_irq_req && !timer_b_irq_req)
    else $error("request with global enable clear");

  AST_FLAG_STICKY:
  assert property ((flag_a_reg && !wr_ctrl) |=> flag_a_reg [*1])
    else $error("overflow flag dropped without a write");

  AST_READ_A_LO:
  assert property ((sfr_rd && sfr_addr == `DTC_ADDR_CNT_A_LO)
                   |=> sfr_rdata == $past(cnt_a_lo_reg))
    else $error("low byte read returned wrong data");

  COV_RELOAD: cover property (mode_a == dtc_pkg::DTC_MODE_8R && ovf_a);
  COV_SPLIT_OVF: cover property (ovf_split_high ##1 flag_b_reg);
  COV_IRQ_A: cover property ($rose(timer_a_irq_req));
  COV_EDGE_COUNT: cover property (src_a && inc_low_a);

endmodule : dtc_top

//--- testbench/tb_top.sv
`include "dtc_params.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic       core_clk;
  logic       rst_n;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       ext_irq_pin_a;
  logic       count_input_pin_a;
  logic       ext_irq_pin_b;
  logic       count_input_pin_b;
  logic       timer_a_ovf_flag;
  logic       timer_b_ovf_flag;
  logic       timer_a_irq_req;
  logic       timer_b_irq_req;
  logic       irq_global_on;
  int         num_errors;
  int         compares;

  dtc_top u_dtc_top (
    .core_clk          (core_clk),
    .rst_n             (rst_n),
    .sfr_addr          (sfr_addr),
    .sfr_wr            (sfr_wr),
    .sfr_rd            (sfr_rd),
    .sfr_wdata         (sfr_wdata),
    .sfr_rdata         (sfr_rdata),
    .ext_irq_pin_a     (ext_irq_pin_a),
    .count_input_pin_a (count_input_pin_a),
    .ext_irq_pin_b     (ext_irq_pin_b),
    .count_input_pin_b (count_input_pin_b),
    .timer_a_ovf_flag  (timer_a_ovf_flag),
    .timer_b_ovf_flag  (timer_b_ovf_flag),
    .timer_a_irq_req   (timer_a_irq_req),
    .timer_b_irq_req   (timer_b_irq_req),
    .irq_global_on     (irq_global_on)
  );

  always #5 core_clk = ~core_clk;

  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk);
    sfr_wr    <= 1'b1;
    sfr_addr  <= addr;
    sfr_wdata <= data;
    @(posedge core_clk);
    sfr_wr    <= 1'b0;
  endtask : sfr_write

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp,
                        input string what);
    @(posedge core_clk);
    sfr_rd   <= 1'b1;
    sfr_addr <= addr;
    @(posedge core_clk);
    sfr_rd   <= 1'b0;
    @(posedge core_clk);
    #1;
    check(sfr_rdata, exp, what);
  endtask : rd_chk

  // Runs for k+2 counting cycles, checks flags before the stopping write
  task automatic run_for(input logic [7:0] ctrl, input int k,
                         input logic fa, input logic fb);
    sfr_write(`DTC_ADDR_CTRL, ctrl);
    repeat (k) @(posedge core_clk);
    #1;
    check(timer_a_ovf_flag, fa, "flag a");
    check(timer_b_ovf_flag, fb, "flag b");
    sfr_write(`DTC_ADDR_CTRL, 8'h00);
  endtask : run_for

  task automatic load(input logic [7:0] mode, input logic [7:0] lo,
                      input logic [7:0] hi);
    sfr_write(`DTC_ADDR_MODE, mode);
    sfr_write(`DTC_ADDR_CNT_A_LO, lo);
    sfr_write(`DTC_ADDR_CNT_A_HI, hi);
  endtask : load

  task automatic t_regs;
    #1;
    check(timer_a_ovf_flag, 1'b0, "reset flag a");
    rd_chk(`DTC_ADDR_CNT_A_LO, 8'h00, "reset a lo");
    rd_chk(`DTC_ADDR_CNT_B_LO, 8'h00, "reset b lo");
    rd_chk(`DTC_ADDR_CNT_A_HI, 8'h00, "reset a hi");
    rd_chk(`DTC_ADDR_IRQ_MASK, 8'h00, "reset irq mask");
    sfr_write(8'h90, 8'h77);
    rd_chk(8'h90, 8'h00, "unmapped");
    sfr_write(`DTC_ADDR_CNT_A_LO, 8'ha5);
    sfr_write(`DTC_ADDR_CNT_B_LO, 8'h5a);
    sfr_write(`DTC_ADDR_CNT_A_HI, 8'h3c);
    sfr_write(`DTC_ADDR_IRQ_MASK, 8'hff);
    rd_chk(`DTC_ADDR_CNT_A_LO, 8'ha5, "a lo rw");
    rd_chk(`DTC_ADDR_CNT_B_LO, 8'h5a, "b lo rw");
    rd_chk(`DTC_ADDR_CNT_A_HI, 8'h3c, "a hi rw");
    rd_chk(`DTC_ADDR_IRQ_MASK, 8'hdf, "irq mask rw");
    $display("test regs done");
  endtask : t_regs

  task automatic t_irq;
    logic [7:0] mask_v [5] = '{8'h02, 8'h82, 8'h88, 8'h8a, 8'h0a};
    logic       exp_a [5]  = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    logic       exp_b [5]  = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic       exp_g [5]  = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    sfr_write(`DTC_ADDR_CTRL, 8'ha0);
    for (int i = 0; i < 5; i++) begin
      sfr_write(`DTC_ADDR_IRQ_MASK, mask_v[i]);
      @(posedge core_clk);
      #1;
      check(timer_a_irq_req, exp_a[i], "irq a");
      check(timer_b_irq_req, exp_b[i], "irq b");
      check(irq_global_on, exp_g[i], "global");
    end
    sfr_write(`DTC_ADDR_CTRL, 8'h00);
    $display("test irq done");
  endtask : t_irq

  task automatic t_modes;
    load(8'h01, 8'hfe, 8'hff);
    run_for(8'h10, 4, 1'b1, 1'b0);
    rd_chk(`DTC_ADDR_CNT_A_LO, 8'h04, "mode 1 a lo");
    rd_chk(`DTC_ADDR_CNT_A_HI, 8'h00, "mode 1 a hi");
    load(8'h00, 8'hfe, 8'hff);
    run_for(8'h10, 4, 1'b1, 1'b0);
    rd_chk(`DTC_ADDR_CNT_A_LO, 8'he4, "mode 0 a lo");
    rd_chk(`DTC_ADDR_CNT_A_HI, 8'h00, "mode 0 a hi");
    load(8'h02, 8'hfd, 8'hf0);
    run_for(8'h10, 4, 1'b1, 1'b0);
    rd_chk(`DTC_ADDR_CNT_A_LO, 8'hf3, "mode 2 a lo");
    rd_chk(`DTC_ADDR_CNT_A_HI, 8'hf0, "mode 2 a hi");
    $display("test modes done");
  endtask : t_modes

  task automatic t_gate;
    ext_irq_pin_a <= 1'b0;
    load(8'h09, 8'h00, 8'h00);
    run_for(8'h10, 8, 1'b0, 1'b0);
    rd_chk(`DTC_ADDR_CNT_A_LO, 8'h00, "gate low");
    ext_irq_pin_a <= 1'b1;
    repeat (4) @(posedge core_clk);
    run_for(8'h10, 8, 1'b0, 1'b0);
    rd_chk(`DTC_ADDR_CNT_A_LO, 8'h0a, "gate high");
    ext_irq_pin_a <= 1'b0;
    load(8'h01, 8'h00, 8'h00);
    repeat (4) @(posedge core_clk);
    run_for(8'h10, 8, 1'b0, 1'b0);
    rd_chk(`DTC_ADDR_CNT_A_LO, 8'h0a, "no gate");
    $display("test gate done");
  endtask : t_gate

  task automatic t_ext_count;
    load(8'h05, 8'h00, 8'h00);
    sfr_write(`DTC_ADDR_CTRL, 8'h10);
    for (int i = 0; i < 3; i++) begin
      count_input_pin_a <= 1'b1;
      repeat (4) @(posedge core_clk);
      count_input_pin_a <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
    sfr_write(`DTC_ADDR_CTRL, 8'h00);
    rd_chk(`DTC_ADDR_CNT_A_LO, 8'h03, "edges");
    $display("test ext count done");
  endtask : t_ext_count

  task automatic t_split;
    load(8'h33, 8'h00, 8'hfe);
    sfr_write(`DTC_ADDR_CNT_B_LO, 8'h55);
    run_for(8'h50, 4, 1'b0, 1'b1);
    rd_chk(`DTC_ADDR_CNT_A_LO, 8'h06, "split a lo");
    rd_chk(`DTC_ADDR_CNT_A_HI, 8'h04, "split a hi");
    rd_chk(`DTC_ADDR_CNT_B_LO, 8'h55, "timer b held");
    run_for(8'h40, 2, 1'b0, 1'b0);
    rd_chk(`DTC_ADDR_CNT_A_LO, 8'h06, "a lo idle");
    rd_chk(`DTC_ADDR_CNT_A_HI, 8'h08, "a hi on run b");
    $display("test split done");
  endtask : t_split

  task automatic t_timer_b;
    sfr_write(`DTC_ADDR_MODE, 8'h10);
    sfr_write(`DTC_ADDR_CNT_B_LO, 8'hfe);
    sfr_write(`DTC_ADDR_TH1, 8'hff);
    run_for(8'h40, 4, 1'b0, 1'b1);
    rd_chk(`DTC_ADDR_CNT_B_LO, 8'h04, "b lo 16-bit");
    rd_chk(`DTC_ADDR_TH1, 8'h00, "b hi 16-bit");
    $display("test timer b done");
  endtask : t_timer_b

  task automatic test_done;
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    $display("[FAIL] %0t run limit reached", $time);
    test_done();
  end

  initial begin
    core_clk          = 1'b0;
    rst_n             = 1'b0;
    sfr_addr          = 8'h00;
    sfr_wr            = 1'b0;
    sfr_rd            = 1'b0;
    sfr_wdata         = 8'h00;
    ext_irq_pin_a     = 1'b0;
    count_input_pin_a = 1'b0;
    ext_irq_pin_b     = 1'b0;
    count_input_pin_b = 1'b0;
    num_errors        = 0;
    compares          = 0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_irq();
    t_modes();
    t_gate();
    t_ext_count();
    t_split();
    t_timer_b();
    test_done();
  end
endmodule : tb_top
